// File: ddeic_pkg.sv
package ddeic_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_CTRL_A   = 4'h0;
    localparam logic [3:0] IDX_CTRL_B   = 4'h1;
    localparam logic [3:0] IDX_EVCTL    = 4'h2;
    localparam logic [3:0] IDX_IEN_CLR  = 4'h4;
    localparam logic [3:0] IDX_IEN_SET  = 4'h5;
    localparam logic [3:0] IDX_FLAGS    = 4'h6;
    localparam logic [3:0] IDX_STATUS   = 4'h7;
    localparam logic [3:0] IDX_CONV     = 4'h8;
    localparam logic [3:0] IDX_BUF      = 4'hC;
    // field positions
    localparam int CA_SOFT_RESET_BIT    = 0;
    localparam int CA_ENABLE   = 1;
    localparam int CB_DRIVE    = 0;
    localparam int CB_LEFT     = 2;
    localparam int EV_START    = 0;
    localparam int EV_EMPTY    = 1;
    localparam int IRQ_UNDER   = 0;
    localparam int IRQ_EMPTY   = 1;
    localparam int IRQ_SYNC    = 2;
    localparam int ST_BUSY     = 7;
    // reset values
    localparam logic [15:0] VAL_RST  = 16'h0000;
    localparam logic [2:0]  IRQ_RST  = 3'h0;
    // timing: cross-domain settle time, rounded up to whole cycles
    localparam int CLK_PERIOD_NS = 40;
    localparam int SYNC_TIME_NS  = 160;
    localparam logic [2:0] SYNC_CNT =
        3'((SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // captured bus data phase
    typedef struct packed {
        logic       vld;
        logic       wr;
        logic [3:0] idx;
    } ddeic_dphase_type;
endpackage

// File: ddeic_top.sv
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - drive bit routes buffer to output pin
// - empty event only when its enable set
// - enabled start event loads buffer, starts conversion
// - reserved bits read back as zero
// - clear-register one bits drop enables
// - set-register one bits raise enables
// - both enable registers read one state
// - busy falling sets sync flag, except enable/reset
// - enabled set flag raises interrupt line
// - writing one clears an interrupt flag
// - buffer write clears buffer-empty flag
// - buffer transfer sets buffer-empty flag
// - start with empty buffer sets underrun
// - status bit seven shows sync busy
// - ten-bit value right or left aligned
// - synced access while busy stalls the bus
// - buffer holds next value, same alignment
module ddeic_top (
    input  wire logic        I_CLOCK,      // 25 MHz bus clock
    input  wire logic        I_RESET_N,    // async reset
    input  wire logic        I_CLK_EN,     // low freezes all state
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    input  wire logic        I_START_EVT,  // start event pulse
    output logic             O_EMPTY_EVT,  // buffer empty event pulse
    output logic             O_CONV_START, // new conversion pulse
    output logic      [9:0]  O_DAC_CODE,   // value to converter
    output logic             O_VOUT_DRIVE, // output buffer on pin
    output logic             O_IRQ         // interrupt level
);
    ddeic_pkg::ddeic_dphase_type dp_ff;    // pending data phase
    logic        rd_ok_ff;                 // read data ready
    logic [31:0] hrdata_ff;                // read data
    logic        busy_ff;                  // sync in progress
    logic [2:0]  cnt_ff;                   // sync cycles left
    logic        quiet_ff;                 // sync from enable/reset
    logic        soft_reset_bit_ff;                 // soft reset pending
    logic        enable_ff;                // converter enabled
    logic        drive_ff;                 // ext output drive on
    logic        left_ff;                  // left alignment
    logic        ev_start_ff;              // start event input en
    logic        ev_empty_ff;              // empty event output en
    logic [2:0]  ien_ff;                   // interrupt enables
    logic [2:0]  flag_ff;                  // interrupt flags
    logic [15:0] conv_ff;                  // conversion value
    logic [15:0] buf_ff;                   // next value buffer
    logic        full_ff;                  // buffer holds new data
    logic        evt_ff;                   // empty event out
    logic        start_ff;                 // conversion start out
    logic [9:0]  code_ff;                  // aligned code out
    logic [3:0]  idx;                      // data phase index
    logic        sync_w;                   // write needs sync
    logic        sync_r;                   // read needs sync
    logic        wr_go;                    // write completes now
    logic        rd_load;                  // read data captured now
    logic [7:0]  wd;                       // write data low byte
    logic        w_ctrl_a;
    logic        w_ctrl_b;
    logic        w_evctl;
    logic        w_ien_clr;
    logic        w_ien_set;
    logic        w_flags;
    logic        w_conv;
    logic        w_buf;
    logic        soft_reset_bit_req;                // soft reset written
    logic        sync_go;                  // sync starts
    logic        sync_last;                // sync ends at next edge
    logic        soft_clr;                 // soft reset completes
    logic        fire;                     // accepted start event
    logic        xfer;                     // buffer moves to value
    logic        under;                    // start with empty buffer
    logic [2:0]  flag_set;                 // hardware flag sets
    logic [31:0] rd_val;                   // read mux

    // data phase decode
    always_comb
    begin
        idx    = dp_ff.idx;
        sync_w = (idx == ddeic_pkg::IDX_CTRL_A) || (idx == ddeic_pkg::IDX_CONV)
                 || (idx == ddeic_pkg::IDX_BUF);
        sync_r = (idx == ddeic_pkg::IDX_CONV);
        wd     = I_HWDATA[7:0];
    end

    // ready: synced writes wait for busy to drop, reads take one wait, value reads also wait for busy to drop
    always_comb
    begin
        if (!dp_ff.vld)
            O_HREADYOUT = 1'b1;
        else if (dp_ff.wr)
            O_HREADYOUT = !(busy_ff && sync_w);
        else
            O_HREADYOUT = rd_ok_ff;
    end

    assign O_HRESP  = 1'b0;
    assign O_HRDATA = hrdata_ff;
    assign wr_go    = I_CLK_EN && dp_ff.vld && dp_ff.wr && O_HREADYOUT;
    assign rd_load  = dp_ff.vld && !dp_ff.wr && !rd_ok_ff
                      && !(busy_ff && sync_r);

    // write strobes per register
    always_comb
    begin
        w_ctrl_a  = wr_go && (idx == ddeic_pkg::IDX_CTRL_A);
        w_ctrl_b  = wr_go && (idx == ddeic_pkg::IDX_CTRL_B);
        w_evctl   = wr_go && (idx == ddeic_pkg::IDX_EVCTL);
        w_ien_clr = wr_go && (idx == ddeic_pkg::IDX_IEN_CLR);
        w_ien_set = wr_go && (idx == ddeic_pkg::IDX_IEN_SET);
        w_flags   = wr_go && (idx == ddeic_pkg::IDX_FLAGS);
        w_conv    = wr_go && (idx == ddeic_pkg::IDX_CONV);
        w_buf     = wr_go && (idx == ddeic_pkg::IDX_BUF);
        soft_reset_bit_req = w_ctrl_a && wd[ddeic_pkg::CA_SOFT_RESET_BIT];
        sync_go   = w_ctrl_a || w_conv || w_buf;
        sync_last = busy_ff && (cnt_ff == 3'h1);
        soft_clr  = sync_last && soft_reset_bit_ff;
    end

    // start event handling
    always_comb
    begin
        fire  = I_START_EVT && ev_start_ff && enable_ff && !soft_reset_bit_ff;
        xfer  = fire && full_ff;
        under = fire && !full_ff;
        flag_set = 3'h0;
        flag_set[ddeic_pkg::IRQ_UNDER] = under;
        flag_set[ddeic_pkg::IRQ_EMPTY] = xfer;
        flag_set[ddeic_pkg::IRQ_SYNC]  = sync_last && !quiet_ff;
    end

    // address phase capture
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            dp_ff <= '0;
        else if (I_CLK_EN && I_HREADY)
        begin
            dp_ff.vld <= I_HSEL && I_HTRANS[1] && (I_HADDR[31:6] == 26'h0);
            dp_ff.wr  <= I_HWRITE;
            dp_ff.idx <= I_HADDR[5:2];
        end
    end

    // read mux, reserved and unmapped bits zero
    always_comb
    begin
        rd_val = 32'h0;
        case (idx)
            ddeic_pkg::IDX_CTRL_A:
            begin
                rd_val[ddeic_pkg::CA_SOFT_RESET_BIT]  = soft_reset_bit_ff;
                rd_val[ddeic_pkg::CA_ENABLE] = enable_ff;
            end
            ddeic_pkg::IDX_CTRL_B:
            begin
                rd_val[ddeic_pkg::CB_DRIVE] = drive_ff;
                rd_val[ddeic_pkg::CB_LEFT]  = left_ff;
            end
            ddeic_pkg::IDX_EVCTL:
            begin
                rd_val[ddeic_pkg::EV_START] = ev_start_ff;
                rd_val[ddeic_pkg::EV_EMPTY] = ev_empty_ff;
            end
            ddeic_pkg::IDX_IEN_CLR: rd_val[2:0] = ien_ff;
            ddeic_pkg::IDX_IEN_SET: rd_val[2:0] = ien_ff;
            ddeic_pkg::IDX_FLAGS:   rd_val[2:0] = flag_ff;
            ddeic_pkg::IDX_STATUS:  rd_val[ddeic_pkg::ST_BUSY] = busy_ff;
            ddeic_pkg::IDX_CONV:    rd_val[15:0] = conv_ff;
            ddeic_pkg::IDX_BUF:     rd_val[15:0] = buf_ff;
            default:                rd_val = 32'h0;
        endcase
    end

    // read data register, one wait state per read, longer for a value read while busy
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            rd_ok_ff  <= 1'b0;
            hrdata_ff <= 32'h0;
        end
        else if (I_CLK_EN)
        begin
            rd_ok_ff <= rd_load;
            if (rd_load)
                hrdata_ff <= rd_val;
        end
    end

    // sync busy counter; synced writes only land while idle
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            busy_ff  <= 1'b0;
            cnt_ff   <= 3'h0;
            quiet_ff <= 1'b0;
            soft_reset_bit_ff <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            if (sync_go)
            begin
                busy_ff  <= 1'b1;
                cnt_ff   <= ddeic_pkg::SYNC_CNT;
                quiet_ff <= w_ctrl_a;
                soft_reset_bit_ff <= soft_reset_bit_req;
            end
            else if (busy_ff)
            begin
                cnt_ff <= cnt_ff - 3'h1;
                if (sync_last)
                begin
                    busy_ff  <= 1'b0;
                    soft_reset_bit_ff <= 1'b0;
                end
            end
        end
    end

    // control registers; soft reset write discards other bits
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            enable_ff   <= 1'b0;
            drive_ff    <= 1'b0;
            left_ff     <= 1'b0;
            ev_start_ff <= 1'b0;
            ev_empty_ff <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            if (soft_clr || soft_reset_bit_req)
            begin
                enable_ff   <= 1'b0;
                drive_ff    <= 1'b0;
                left_ff     <= 1'b0;
                ev_start_ff <= 1'b0;
                ev_empty_ff <= 1'b0;
            end
            else
            begin
                if (w_ctrl_a)
                    enable_ff <= wd[ddeic_pkg::CA_ENABLE];
                if (w_ctrl_b)
                begin
                    drive_ff <= wd[ddeic_pkg::CB_DRIVE];
                    left_ff  <= wd[ddeic_pkg::CB_LEFT];
                end
                if (w_evctl)
                begin
                    ev_start_ff <= wd[ddeic_pkg::EV_START];
                    ev_empty_ff <= wd[ddeic_pkg::EV_EMPTY];
                end
            end
        end
    end

    // interrupt enables: shared by set and clear registers
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            ien_ff <= ddeic_pkg::IRQ_RST;
        else if (I_CLK_EN)
        begin
            if (soft_clr)
                ien_ff <= ddeic_pkg::IRQ_RST;
            else if (w_ien_clr)
                ien_ff <= ien_ff & ~wd[2:0];
            else if (w_ien_set)
                ien_ff <= ien_ff | wd[2:0];
        end
    end

    // interrupt flags: hardware set wins over software clear
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            flag_ff <= ddeic_pkg::IRQ_RST;
        else if (I_CLK_EN)
        begin
            if (soft_clr)
                flag_ff <= ddeic_pkg::IRQ_RST;
            else
            begin
                for (int i = 0; i < 3; i++)
                begin
                    if (flag_set[i])
                        flag_ff[i] <= 1'b1;
                    else if (w_flags && wd[i])
                        flag_ff[i] <= 1'b0;
                    else if (w_buf && (i == ddeic_pkg::IRQ_EMPTY))
                        flag_ff[i] <= 1'b0;
                end
            end
        end
    end

    // value and buffer; a buffer write beats a same-cycle transfer
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            conv_ff <= ddeic_pkg::VAL_RST;
            buf_ff  <= ddeic_pkg::VAL_RST;
            full_ff <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            if (soft_clr)
            begin
                conv_ff <= ddeic_pkg::VAL_RST;
                buf_ff  <= ddeic_pkg::VAL_RST;
                full_ff <= 1'b0;
            end
            else
            begin
                if (xfer)
                    conv_ff <= buf_ff;
                else if (w_conv)
                    conv_ff <= I_HWDATA[15:0];
                if (w_buf)
                begin
                    buf_ff  <= I_HWDATA[15:0];
                    full_ff <= 1'b1;
                end
                else if (xfer)
                    full_ff <= 1'b0;
            end
        end
    end

    // outputs to converter and event fabric
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            evt_ff   <= 1'b0;
            start_ff <= 1'b0;
            code_ff  <= 10'h000;
        end
        else if (I_CLK_EN)
        begin
            evt_ff   <= xfer && ev_empty_ff;
            start_ff <= xfer || w_conv;
            code_ff  <= left_ff ? conv_ff[15:6] : conv_ff[9:0];
        end
    end

    assign O_EMPTY_EVT  = evt_ff;
    assign O_CONV_START = start_ff;
    assign O_DAC_CODE   = code_ff;
    assign O_VOUT_DRIVE = drive_ff;
    assign O_IRQ        = |(flag_ff & ien_ff);

    // checks
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);

    property p_drive;
        (I_CLK_EN && w_ctrl_b && !soft_reset_bit_req && !soft_clr) |=> (O_VOUT_DRIVE == $past(wd[0]));
    endproperty
    a_drive: assert property (p_drive) else $error("drive bit not on pin");

    property p_evt_gate;
        O_EMPTY_EVT |-> $past(ev_empty_ff) && $past(xfer) && !$past(O_EMPTY_EVT);
    endproperty
    a_evt_gate: assert property (p_evt_gate) else $error("bad empty event");

    property p_xfer;
        (I_CLK_EN && xfer && !w_buf && !soft_clr)
            |=> O_CONV_START && !full_ff && conv_ff == $past(buf_ff);
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer failed");

    property p_rsv;
        (rd_ok_ff && idx == ddeic_pkg::IDX_FLAGS) |-> O_HRDATA[31:3] == 29'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");

    property p_ien_clr;
        (I_CLK_EN && w_ien_clr && wd[0] && !soft_clr) |=> !ien_ff[0];
    endproperty
    a_ien_clr: assert property (p_ien_clr) else $error("enable not cleared");

    property p_ien_set;
        (I_CLK_EN && w_ien_set && wd[1] && !soft_clr) |=> ien_ff[1];
    endproperty
    a_ien_set: assert property (p_ien_set) else $error("enable not set");

    property p_sync_done_flag;
        (I_CLK_EN && sync_last && !quiet_ff) |=> !busy_ff && flag_ff[2];
    endproperty
    a_sync_done_flag: assert property (p_sync_done_flag) else $error("sync flag missing");

    property p_irq;
        (flag_ff[0] && ien_ff[0]) |-> O_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    property p_under;
        (I_CLK_EN && under && !soft_clr) |=> flag_ff[0];
    endproperty
    a_under: assert property (p_under) else $error("underrun missed");

    property p_busy;
        (I_CLK_EN && sync_go) |=> busy_ff [*4];
    endproperty
    a_busy: assert property (p_busy) else $error("busy too short");

    property p_stall;
        (dp_ff.vld && dp_ff.wr && sync_w && busy_ff) |-> !O_HREADYOUT;
    endproperty
    a_stall: assert property (p_stall) else $error("no stall");

    c_xfer:  cover property (I_CLK_EN && xfer);
    c_under: cover property (I_CLK_EN && under);
    c_stall: cover property (dp_ff.vld && !O_HREADYOUT ##1 O_HREADYOUT);
endmodule
`default_nettype wire

// File: ddeic_evt_src.sv
`timescale 1ns/1ps
`default_nettype none
// event routing fabric model: relays start requests and counts empty events
module ddeic_evt_src (
    input  wire logic        i_clock,     // bus clock
    input  wire logic        i_reset_n,   // async reset, active low
    input  wire logic        i_fire,      // bench asks for one start event
    input  wire logic        i_empty_evt, // buffer-empty event from the block
    output logic             o_start_evt, // routed start event pulse
    output logic      [15:0] o_empty_cnt  // empty events seen so far
);
    // start pulse leaves one edge after the request, as a routed channel does
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_start_evt <= 1'b0;
        else
            o_start_evt <= i_fire;
    end

    // each cycle high counts as one event, so a stretched pulse shows up
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_empty_cnt <= 16'h0000;
        else if (i_empty_evt === 1'b1)
            o_empty_cnt <= o_empty_cnt + 16'h0001;
    end
endmodule
`default_nettype wire

// File: ddeic_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ddeic_top_tb;
    logic        clk    = 1'b0;  // 25 MHz bus clock
    logic        rst_n  = 1'b0;  // reset, active low
    logic        hsel   = 1'b0;  // bus select
    logic [31:0] haddr  = 32'h0;  // bus address
    logic [1:0]  htrans = 2'h0;  // transfer kind
    logic        hwrite = 1'b0;  // write strobe
    logic [31:0] hwdata = 32'h0;  // write data
    logic        fire   = 1'b0;  // ask partner for a start event
    logic        en     = 1'b1;  // clock enable, low freezes the block
    logic [31:0] hrdata;         // read data
    logic        hready;         // slave ready, looped back
    logic        hresp;          // response code
    logic        start;          // start event into block
    logic        empty_evt;      // empty event out of block
    logic        conv_start;     // conversion pulse
    logic [9:0]  dac;            // code to converter
    logic        drive;          // output pin drive
    logic        irq;            // interrupt line
    logic [15:0] empty_cnt;      // empty events counted by partner
    int          conv_cnt = 0;   // conversion pulses seen
    int          fails = 0;      // mismatches
    int          tests_run = 0;  // comparisons made
    int          ien = 0;        // model of interrupt enables
    int          flg = 0;        // model of interrupt flags
    int          c0;             // conversion count before an event
    int          e0;             // empty count before an event
    logic [9:0]  v;              // random converter code
    logic [31:0] junk;           // discarded read data
    logic [3:0]  idxs[7] = '{ddeic_pkg::IDX_EVCTL, ddeic_pkg::IDX_IEN_SET,
        ddeic_pkg::IDX_IEN_CLR, ddeic_pkg::IDX_FLAGS, ddeic_pkg::IDX_STATUS,
        ddeic_pkg::IDX_CONV, 4'hF};  // reset-value reads, last one unmapped

    always #20 clk = ~clk;

    ddeic_top ddeic_top_i (
        .I_CLOCK(clk), .I_RESET_N(rst_n), .I_CLK_EN(en), .I_HSEL(hsel),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .I_START_EVT(start),
        .O_EMPTY_EVT(empty_evt), .O_CONV_START(conv_start), .O_DAC_CODE(dac),
        .O_VOUT_DRIVE(drive), .O_IRQ(irq)
    );

    ddeic_evt_src ddeic_evt_src_i (
        .i_clock(clk), .i_reset_n(rst_n), .i_fire(fire), .i_empty_evt(empty_evt),
        .o_start_evt(start), .o_empty_cnt(empty_cnt)
    );

    // count conversion pulses for the event checks
    always @(posedge clk)
    begin
        if (conv_start === 1'b1)
            conv_cnt++;
    end

    // compare one value and report a mismatch at once
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    // wait for ready sampled high at a rising edge; only the watchdog ends a hang
    task automatic wait_rdy();
        do
        begin
            @(posedge clk);
        end
        while (hready !== 1'b1);
    endtask

    // one single word transfer, held until the slave answers
    task automatic bus(input logic [3:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {26'h0, idx, 2'h0};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // register write
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        bus(idx, 1'b1, d, junk);
    endtask

    // register read and compare
    task automatic rc(input string n, input logic [3:0] idx, input logic [31:0] e);
        logic [31:0] d;
        bus(idx, 1'b0, 32'h0, d);
        chk(n, e, d);
    endtask

    // interrupt line against the model
    task automatic ci();
        chk("irq", {31'h0, (flg & ien) != 0}, {31'h0, irq});
    endtask

    // one start event through the partner, then let the result settle
    task automatic fire_evt();
        c0 = conv_cnt;
        e0 = int'(empty_cnt);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a hang counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        stop_test();
    end

    initial
    begin
        void'($urandom(38));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (idxs[i]) rc("reset value", idxs[i], 32'h0);
        $display("test reset values done");
        wr(ddeic_pkg::IDX_EVCTL, 32'hFF);
        rc("evctl", ddeic_pkg::IDX_EVCTL, 32'h3);
        wr(ddeic_pkg::IDX_IEN_SET, 32'hFF);
        ien = 7;
        rc("ien set", ddeic_pkg::IDX_IEN_SET, 32'h7);
        rc("ien clr", ddeic_pkg::IDX_IEN_CLR, 32'h7);
        wr(ddeic_pkg::IDX_IEN_CLR, 32'h0A);
        ien = 5;
        rc("ien clr", ddeic_pkg::IDX_IEN_CLR, 32'h5);
        rc("ien set", ddeic_pkg::IDX_IEN_SET, 32'h5);
        wr(ddeic_pkg::IDX_CTRL_B, 32'h1);
        @(posedge clk);
        chk("drive", 32'h1, {31'h0, drive});
        $display("test enables done");
        wr(ddeic_pkg::IDX_CTRL_A, 32'h2);
        repeat (8) @(posedge clk);
        rc("flags after enable", ddeic_pkg::IDX_FLAGS, 32'h0);
        v = 10'($urandom);
        wr(ddeic_pkg::IDX_BUF, {22'h0, v});
        rc("status busy", ddeic_pkg::IDX_STATUS, 32'h80);
        repeat (8) @(posedge clk);
        rc("status idle", ddeic_pkg::IDX_STATUS, 32'h0);
        flg = 4;
        rc("flags sync", ddeic_pkg::IDX_FLAGS, 32'h4);
        ci();
        fire_evt();
        chk("conv pulses", 32'(c0 + 1), 32'(conv_cnt));
        chk("empty events", 32'(e0 + 1), {16'h0, empty_cnt});
        chk("dac code", {22'h0, v}, {22'h0, dac});
        flg = 6;
        rc("flags empty", ddeic_pkg::IDX_FLAGS, 32'h6);
        rc("value", ddeic_pkg::IDX_CONV, {22'h0, v});
        wr(ddeic_pkg::IDX_FLAGS, 32'h4);
        flg = 2;
        rc("flags w1c", ddeic_pkg::IDX_FLAGS, 32'h2);
        ci();
        fire_evt();
        flg = 3;
        rc("flags underrun", ddeic_pkg::IDX_FLAGS, 32'h3);
        ci();
        $display("test right aligned transfer done");
        wr(ddeic_pkg::IDX_CTRL_B, 32'h4);
        @(posedge clk);
        chk("drive", 32'h0, {31'h0, drive});
        v = 10'($urandom);
        wr(ddeic_pkg::IDX_BUF, {16'h0, v, 6'h0});
        repeat (8) @(posedge clk);
        flg = 5;
        rc("flags buffer write", ddeic_pkg::IDX_FLAGS, 32'h5);
        wr(ddeic_pkg::IDX_EVCTL, 32'h1);
        fire_evt();
        chk("conv pulses", 32'(c0 + 1), 32'(conv_cnt));
        chk("empty events", 32'(e0), {16'h0, empty_cnt});
        chk("dac code", {22'h0, v}, {22'h0, dac});
        rc("value left", ddeic_pkg::IDX_CONV, {16'h0, v, 6'h0});
        wr(ddeic_pkg::IDX_EVCTL, 32'h0);
        fire_evt();
        chk("conv pulses", 32'(c0), 32'(conv_cnt));
        flg = 7;
        rc("flags ignored", ddeic_pkg::IDX_FLAGS, 32'h7);
        $display("test left aligned transfer done");
        wr(ddeic_pkg::IDX_BUF, 32'h0000FFC0);
        wr(ddeic_pkg::IDX_CONV, 32'h00000240);
        rc("value after stall", ddeic_pkg::IDX_CONV, 32'h240);
        repeat (8) @(posedge clk);
        flg = 5;
        rc("flags after stall", ddeic_pkg::IDX_FLAGS, 32'h5);
        ci();
        $display("test busy stall done");
        wr(ddeic_pkg::IDX_BUF, 32'h000003FF);
        en <= 1'b0;
        repeat (8) @(posedge clk);
        en <= 1'b1;
        rc("status frozen", ddeic_pkg::IDX_STATUS, 32'h80);
        wr(ddeic_pkg::IDX_CTRL_A, 32'h3);
        rc("soft reset pending", ddeic_pkg::IDX_CTRL_A, 32'h1);
        repeat (8) @(posedge clk);
        ien = 0;
        flg = 0;
        rc("flags soft reset", ddeic_pkg::IDX_FLAGS, 32'h0);
        rc("ien soft reset", ddeic_pkg::IDX_IEN_SET, 32'h0);
        rc("ctrl a after reset", ddeic_pkg::IDX_CTRL_A, 32'h0);
        ci();
        $display("test freeze and soft reset done");
        stop_test();
    end
endmodule
`default_nettype wire
